// ### asu_core.sv
`timescale 1ns/1ps
module asu_core #(
	parameter int DATA_W    = 12,
	parameter int BUF_DEPTH = 2,
	parameter int NCHAN     = 8
) (
	input  wire logic              sys_clk,
	input  wire logic              resetn,
	input  wire logic [4:0]        io_addr,
	input  wire logic              io_wr,
	input  wire logic              io_rd,
	input  wire logic [7:0]        io_wdata,
	output logic [7:0]             io_rdata,
	output logic                   irq,
	input  wire logic              conv_valid,
	output logic                   conv_ready,
	input  wire logic [DATA_W-1:0] conv_data,
	output logic                   run_start,
	output logic [2:0]             run_first,
	output logic [2:0]             run_last,
	output logic [7:0]             range_sel
);
	// ==========================================================
	// state
	logic [7:0]        io_rdata_r;
	logic              irq_r;
	logic              run_start_r;
	logic [2:0]        run_first_r;
	logic [2:0]        run_last_r;
	logic [7:0]        range_r;
	logic [7:0]        cmd_r;
	logic [7:0]        set_r;
	logic [3:0]        mask_r;
	logic [31:0]       period_r;
	logic [2:0]        chan_r;
	logic [3:0]        flags_r;
	logic [3:0]        flags_nxt;
	logic              busy_r;
	logic [3:0]        exp_r;
	logic [3:0]        rcv_r;
	logic [3:0]        avail_r;
	logic [2:0]        rd_ptr_r;
	logic              timer_on_r;
	logic [7:0]        div_r;
	logic [31:0]       per_cnt_r;
	logic [DATA_W-1:0] res_r [NCHAN];
	logic              buf_valid;
	logic [DATA_W-1:0] buf_data;

	// ==========================================================
	// two-entry buffer between the converter and the result store
	asu_buf #(.W(DATA_W), .DEPTH(BUF_DEPTH)) u_buf (
		.sys_clk   (sys_clk),
		.resetn    (resetn),
		.in_valid  (conv_valid),
		.in_ready  (conv_ready),
		.in_data   (conv_data),
		.out_valid (buf_valid),
		.out_ready (busy_r),
		.out_data  (buf_data)
	);

	// ==========================================================
	// port decode
	wire wr_cmd  = io_wr & (io_addr == asu_pkg::OFF_CMD);
	wire wr_chan = io_wr & (io_addr == asu_pkg::OFF_CHAN);
	wire wr_stat = io_wr & (io_addr == asu_pkg::OFF_STATUS);
	wire wr_d0   = io_wr & (io_addr == asu_pkg::OFF_DATA0);
	wire rd_hi   = io_rd & (io_addr == asu_pkg::OFF_DATA_HI);
	wire clk_mode = set_r[asu_pkg::SET_CLK];
	wire multi    = set_r[asu_pkg::SET_MULTI];

	// command decode [RULE14]
	wire c_init   = wr_cmd & (io_wdata == asu_pkg::CMD_INIT);
	wire c_set    = wr_cmd & (io_wdata == asu_pkg::CMD_SET);
	wire c_tstart = wr_cmd & (io_wdata == asu_pkg::CMD_TSTART);
	wire c_tstop  = wr_cmd & (io_wdata == asu_pkg::CMD_TSTOP);
	wire d_mask   = wr_d0 & (cmd_r == asu_pkg::CMD_MASK);
	wire d_set    = wr_d0 & (cmd_r == asu_pkg::CMD_SET);
	wire d_range  = wr_d0 & (cmd_r == asu_pkg::CMD_RANGE);
	wire d_per    = io_wr & (cmd_r == asu_pkg::CMD_PERIOD)
		& (io_addr[4:2] == asu_pkg::OFF_DATA0[4:2]);

	// ==========================================================
	// sampling clock: 248 ns (62-cycle) step enable, then period count
	wire step_en = (div_r == 8'(asu_pkg::STEP_CYC - 1));
	wire tick_ev = timer_on_r & step_en & (per_cnt_r == period_r);

	// run starts: software channel write, timer start, idle tick
	wire go_sw   = wr_chan & ~clk_mode & ~busy_r;          // [RULE17]
	wire go_clk  = c_tstart & clk_mode & ~busy_r;
	wire go_tick = tick_ev & ~busy_r;                      // [RULE7]
	wire run_go  = go_sw | go_clk | go_tick;
	wire [2:0] go_chan = wr_chan ? io_wdata[2:0] : chan_r;

	// results arriving and batch completion
	wire drain      = buf_valid & busy_r;
	wire batch_done = drain & ((rcv_r + 4'h1) == exp_r);   // [RULE2]
	wire last_read  = rd_hi & (avail_r == 4'h1);

	// ==========================================================
	// flag events: set wins over every clear
	wire [3:0] set_ev;
	assign set_ev[asu_pkg::F_DRE]  = batch_done;           // [RULE1] [RULE2]
	assign set_ev[asu_pkg::F_OVERWRITE_ERROR_FLAG] = batch_done & clk_mode
		& (avail_r != 4'h0);                               // [RULE4]
	assign set_ev[asu_pkg::F_SCI]  = tick_ev;              // [RULE6]
	assign set_ev[asu_pkg::F_SCE]  = tick_ev & busy_r;     // [RULE7]

	wire start_clr = (wr_chan | c_tstart) & ~busy_r;
	wire cmd_clr   = c_init | c_set | start_clr;           // [RULE8]
	wire [3:0] w1c = wr_stat ? asu_pkg::pick4(io_wdata)
		: 4'h0;                                            // [RULE9] [RULE18]
	wire [3:0] auto_clr;
	assign auto_clr[asu_pkg::F_DRE]  = last_read;          // [RULE3]
	assign auto_clr[asu_pkg::F_OVERWRITE_ERROR_FLAG] = batch_done
		& (avail_r == 4'h0);                               // [RULE5]
	assign auto_clr[3:2] = 2'h0;
	assign flags_nxt = (flags_r & ~(w1c | auto_clr | {4{cmd_clr}}))
		| set_ev;

	// interrupt request rises with any enabled flag event
	wire irq_nxt = |(set_ev & ~mask_r);                    // [RULE10] [RULE11] [RULE12]

	// ==========================================================
	// read data mux
	wire [DATA_W-1:0] cur = res_r[rd_ptr_r];
	wire [7:0] st_byte = {2'h0, flags_r[asu_pkg::F_SCE],
		flags_r[asu_pkg::F_SCI], 1'h0, flags_r[asu_pkg::F_OVERWRITE_ERROR_FLAG],
		1'h0, flags_r[asu_pkg::F_DRE]};
	wire [7:0] rd_nxt =
		(io_addr == asu_pkg::OFF_DATA_LO) ? cur[7:0] :
		(io_addr == asu_pkg::OFF_DATA_HI) ? 8'(cur[DATA_W-1:8]) :
		(io_addr == asu_pkg::OFF_STATUS)  ? st_byte : 8'h00;

	assign io_rdata  = io_rdata_r;
	assign irq       = irq_r;
	assign run_start = run_start_r;
	assign run_first = run_first_r;
	assign run_last  = run_last_r;
	assign range_sel = range_r;

	// ==========================================================
	// host port registers
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cmd_r    <= asu_pkg::CMD_INIT;
			set_r    <= asu_pkg::SET_RST;
			mask_r   <= asu_pkg::MASK_RST;
			range_r  <= asu_pkg::RANGE_RST;
			period_r <= asu_pkg::PERIOD_RST;
			chan_r   <= 3'h0;
		end else begin
			if (wr_cmd)
				cmd_r <= io_wdata;
			if (c_init) begin
				set_r  <= asu_pkg::SET_RST;
				mask_r <= asu_pkg::MASK_RST;                // [RULE13]
			end
			if (d_mask)
				mask_r <= asu_pkg::pick4(io_wdata);         // [RULE13]
			if (d_set)
				set_r <= io_wdata;                          // [RULE16]
			if (d_range)
				range_r <= io_wdata;
			if (d_per)
				period_r[io_addr[1:0]*8 +: 8] <= io_wdata;  // [RULE14]
			if (wr_chan)
				chan_r <= io_wdata[2:0];                    // [RULE17]
		end
	end

	// flags, interrupt and read data
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			flags_r    <= 4'h0;
			irq_r      <= 1'h0;
			io_rdata_r <= 8'h00;
		end else begin
			flags_r    <= flags_nxt;
			irq_r      <= irq_nxt;
			io_rdata_r <= io_rd ? rd_nxt : 8'h00;
		end
	end

	// sampling timer, stopped by init, condition and stop commands
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			timer_on_r <= 1'h0;
			div_r      <= 8'h00;
			per_cnt_r  <= 32'h0000_0000;
		end else begin
			div_r <= step_en ? 8'h00 : div_r + 8'h01;
			if (step_en)
				per_cnt_r <= tick_ev ? 32'h0 : per_cnt_r + 32'h1;
			if (c_tstart & clk_mode) begin
				timer_on_r <= 1'h1;
				div_r      <= 8'h00;
				per_cnt_r  <= 32'h0000_0000;
			end
			if (c_init | c_set | c_tstop)
				timer_on_r <= 1'h0;
		end
	end

	// run control and readable result count
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			busy_r      <= 1'h0;
			run_start_r <= 1'h0;
			run_first_r <= 3'h0;
			run_last_r  <= 3'h0;
			exp_r       <= 4'h0;
			rcv_r       <= 4'h0;
			avail_r     <= 4'h0;
			rd_ptr_r    <= 3'h0;
		end else begin
			run_start_r <= run_go;
			if (run_go) begin
				busy_r      <= 1'h1;
				rcv_r       <= 4'h0;
				run_first_r <= multi ? 3'h0 : go_chan;
				run_last_r  <= go_chan;
				exp_r <= multi ? 4'(go_chan) + 4'h1 : 4'h1;
			end
			if (drain)
				rcv_r <= rcv_r + 4'h1;
			if (rd_hi & (avail_r != 4'h0)) begin
				avail_r  <= avail_r - 4'h1;
				rd_ptr_r <= rd_ptr_r + 3'h1;
			end
			if (c_init | c_set | start_clr) begin
				avail_r  <= 4'h0;
				rd_ptr_r <= 3'h0;
			end
			if (batch_done) begin
				busy_r   <= 1'h0;
				avail_r  <= exp_r;
				rd_ptr_r <= 3'h0;
			end
		end
	end

	// result store, written in arrival order
	always_ff @(posedge sys_clk) begin
		if (drain)
			res_r[rcv_r[2:0]] <= buf_data;
	end

	// ==========================================================
	// checks
	dre_cause_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		$rose(flags_r[asu_pkg::F_DRE]) |-> $past(batch_done)) // [RULE2]
		else $error("ready flag rose without complete batch");

	dre_set_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		batch_done |=> flags_r[asu_pkg::F_DRE]) // [RULE1]
		else $error("ready flag missing after batch");

	dre_drop_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		last_read && !batch_done |=> !flags_r[asu_pkg::F_DRE]) // [RULE3]
		else $error("ready flag kept after last read");

	overwrite_error_flag_set_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		batch_done && clk_mode && avail_r != 4'h0
		|=> flags_r[asu_pkg::F_OVERWRITE_ERROR_FLAG]) // [RULE4]
		else $error("overwrite not flagged");

	overwrite_error_flag_drop_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		batch_done && avail_r == 4'h0 |=> !flags_r[asu_pkg::F_OVERWRITE_ERROR_FLAG]) // [RULE5]
		else $error("overwrite flag kept without overwrite");

	sci_set_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		tick_ev |=> flags_r[asu_pkg::F_SCI]) // [RULE6]
		else $error("tick flag missing");

	sce_ignore_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		tick_ev && busy_r |=> flags_r[asu_pkg::F_SCE] && !run_start_r) // [RULE7]
		else $error("busy tick not ignored or not flagged");

	cmd_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		(c_init || c_set) && set_ev == 4'h0 |=> flags_r == 4'h0) // [RULE8]
		else $error("command did not clear flags");

	w1c_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		wr_stat && io_wdata[asu_pkg::ST_SCE] && !set_ev[asu_pkg::F_SCE]
		|=> !flags_r[asu_pkg::F_SCE]) // [RULE9]
		else $error("write one did not clear overrun flag");

	w0_keep_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		wr_stat && !io_wdata[asu_pkg::ST_SCI] && !cmd_clr
		&& flags_r[asu_pkg::F_SCI] |=> flags_r[asu_pkg::F_SCI]) // [RULE18]
		else $error("write zero changed tick flag");

	irq_pair_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		$rose(flags_r[asu_pkg::F_DRE]) && !mask_r[asu_pkg::F_DRE]
		|-> irq_r) // [RULE11]
		else $error("request not with enabled flag");

	irq_tick_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		tick_ev && !mask_r[asu_pkg::F_SCI] |=> irq_r) // [RULE12]
		else $error("tick did not raise request");

	mask_init_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		c_init |=> mask_r == asu_pkg::MASK_RST) // [RULE13]
		else $error("init did not mask sources");

	chan_go_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		go_sw |=> run_start_r && run_last_r == $past(io_wdata[2:0])) // [RULE17]
		else $error("channel write did not start run");
endmodule

// ### asu_pkg.sv
// Notes on behaviour
// (RULE1) single-channel: ready flag once a result stored
// (RULE2) multi-channel: ready flag after whole channel batch
// (RULE3) ready flag drops when all results read
// (RULE4) clock mode: overwrite flag when unread data replaced
// (RULE5) overwrite flag drops once no overwrite happens
// (RULE6) clock mode: tick flag per sampling clock, sticky
// (RULE7) tick while busy: overrun flag, tick ignored
// (RULE8) init, condition, idle start commands clear flags
// (RULE9) writing one to status bit clears flag
// (RULE10) any flag combination may be interrupt source
// (RULE11) interrupt request with the enabled flag's setting
// (RULE12) enabled tick source interrupts on every tick
// (RULE13) command 1 then mask byte; init masks all
// (RULE14) command codes 0 to 6 with their data
// (RULE15) host polls status, reads low then high
// (RULE16) settings: D0 clock mode, D2 multi-channel
// (RULE17) channel write starts; channel or highest channel
// (RULE18) zero bits and unused bits of status ignored
package asu_pkg;
	// ==========================================================
	// port offsets
	localparam logic [4:0] OFF_DATA_LO = 5'h10;
	localparam logic [4:0] OFF_DATA_HI = 5'h11;
	localparam logic [4:0] OFF_CHAN    = 5'h12;
	localparam logic [4:0] OFF_STATUS  = 5'h16;
	localparam logic [4:0] OFF_CMD     = 5'h18;
	localparam logic [4:0] OFF_DATA0   = 5'h1C;
	localparam logic [4:0] OFF_DATA1   = 5'h1D;
	localparam logic [4:0] OFF_DATA2   = 5'h1E;
	localparam logic [4:0] OFF_DATA3   = 5'h1F;
	// ==========================================================
	// command codes
	localparam logic [7:0] CMD_INIT   = 8'h00;
	localparam logic [7:0] CMD_MASK   = 8'h01;
	localparam logic [7:0] CMD_SET    = 8'h02;
	localparam logic [7:0] CMD_RANGE  = 8'h03;
	localparam logic [7:0] CMD_PERIOD = 8'h04;
	localparam logic [7:0] CMD_TSTART = 8'h05;
	localparam logic [7:0] CMD_TSTOP  = 8'h06;
	// ==========================================================
	// field positions
	localparam int ST_DRE    = 0;
	localparam int ST_OVERWRITE_ERROR_FLAG   = 2;
	localparam int ST_SCI    = 4;
	localparam int ST_SCE    = 5;
	localparam int SET_CLK   = 0;
	localparam int SET_MULTI = 2;
	localparam int F_DRE     = 0;
	localparam int F_OVERWRITE_ERROR_FLAG    = 1;
	localparam int F_SCI     = 2;
	localparam int F_SCE     = 3;
	// ==========================================================
	// reset values and timing
	localparam logic [3:0]  MASK_RST   = 4'hF;
	localparam logic [7:0]  SET_RST    = 8'h00;
	localparam logic [7:0]  RANGE_RST  = 8'h00;
	localparam logic [31:0] PERIOD_RST = 32'h0000_0027;
	localparam int CLK_NS   = 4;
	localparam int STEP_NS  = 250;
	localparam int STEP_CYC = STEP_NS / CLK_NS;
	// ==========================================================
	// gather the four flag bits of a status-shaped byte
	function automatic logic [3:0] pick4(input logic [7:0] b);
		pick4 = {b[ST_SCE], b[ST_SCI], b[ST_OVERWRITE_ERROR_FLAG], b[ST_DRE]};
	endfunction
endpackage

// ### asu_buf.sv
`timescale 1ns/1ps
module asu_buf #(
	parameter int W     = 12,
	parameter int DEPTH = 2
) (
	input  wire logic         sys_clk,
	input  wire logic         resetn,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0]  mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0]   cnt_r;
	logic [AW:0]   cnt_nxt;
	logic          in_ready_r;
	wire           push;
	wire           pop;

	// pointer step with wrap at the depth
	function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
		step = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
	endfunction

	// handshakes and fill level
	assign push      = in_valid & in_ready_r;
	assign pop       = out_valid & out_ready;
	assign cnt_nxt   = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
	assign in_ready  = in_ready_r;
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem_r[rd_ptr_r];

	// pointers, level and registered ready
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr_r   <= '0;
			rd_ptr_r   <= '0;
			cnt_r      <= '0;
			in_ready_r <= 1'h0;
		end else begin
			if (push)
				wr_ptr_r <= step(wr_ptr_r);
			if (pop)
				rd_ptr_r <= step(rd_ptr_r);
			cnt_r      <= cnt_nxt;
			in_ready_r <= (cnt_nxt < (AW+1)'(DEPTH));
		end
	end

	// storage needs no reset
	always_ff @(posedge sys_clk) begin
		if (push)
			mem_r[wr_ptr_r] <= in_data;
	end

	buf_level_a: assert property (@(posedge sys_clk) disable iff (!resetn)
		cnt_r <= (AW+1)'(DEPTH))
		else $error("buffer level above depth");
endmodule

// ### asu_conv_model.sv
`timescale 1ns/1ps
// ==========================================================
// converter model: one word per channel of every run
module asu_conv_model (
	input  wire logic        sys_clk,
	input  wire logic        resetn,
	input  wire logic        run_start,
	input  wire logic [2:0]  run_first,
	input  wire logic [2:0]  run_last,
	input  wire logic        conv_ready,
	input  wire logic [3:0]  gap,
	output logic             conv_valid,
	output logic [11:0]      conv_data
);
	logic hs;
	// words go out in channel order, held until ready is seen
	initial begin
		conv_valid = 1'b0;
		conv_data  = 12'h000;
		forever begin
			@(posedge sys_clk);
			#1;
			if (resetn && run_start) begin
				for (int ch = run_first; ch <= run_last; ch++) begin
					repeat (gap) begin
						@(posedge sys_clk);
						#1;
					end
					conv_valid = 1'b1;
					conv_data  = 12'h800 + 12'(ch) * 12'h111;
					hs         = 1'b0;
					while (!hs) begin
						hs = conv_ready; // registered, stable all cycle
						@(posedge sys_clk);
						#1;
					end
					if (gap != 4'h0 || ch == int'(run_last)) begin
						conv_valid = 1'b0;
						conv_data  = ~conv_data; // no stale word left
					end
				end
			end
		end
	end
endmodule

// ### adc_status_interrupt_unit_tb_top.sv
`timescale 1ns/1ps
module adc_status_interrupt_unit_tb_top;
	logic        sys_clk;
	logic        resetn;
	logic [4:0]  io_addr;
	logic        io_wr;
	logic        io_rd;
	logic [7:0]  io_wdata;
	logic [7:0]  io_rdata;
	logic        irq;
	logic        conv_valid;
	logic        conv_ready;
	logic [11:0] conv_data;
	logic        run_start;
	logic [2:0]  run_first;
	logic [2:0]  run_last;
	logic [7:0]  range_sel;
	logic [3:0]  gap;
	logic [2:0]  rf;
	logic [2:0]  rl;
	logic [7:0]  s;
	logic [7:0]  lo;
	logic [7:0]  hi;
	int          bad_count;
	int          checked;
	int          cyc;
	int          irq_cnt;
	int          irq_at;
	int          irq_prev;
	int          runs;
	int          k;

	// ==========================================================
	// design and converter model
	asu_core dut (.sys_clk(sys_clk), .resetn(resetn), .io_addr(io_addr),
		.io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
		.io_rdata(io_rdata), .irq(irq), .conv_valid(conv_valid),
		.conv_ready(conv_ready), .conv_data(conv_data),
		.run_start(run_start), .run_first(run_first),
		.run_last(run_last), .range_sel(range_sel));
	asu_conv_model conv (.sys_clk(sys_clk), .resetn(resetn),
		.run_start(run_start), .run_first(run_first),
		.run_last(run_last), .conv_ready(conv_ready), .gap(gap),
		.conv_valid(conv_valid), .conv_data(conv_data));

	// ==========================================================
	// clock, hang limit and event monitor
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	always @(negedge sys_clk) begin
		cyc++;
		if (irq === 1'b1) begin
			irq_cnt++;
			irq_prev = irq_at;
			irq_at   = cyc;
		end
		if (run_start === 1'b1) begin
			runs++;
			rf = run_first;
			rl = run_last;
		end
		if (cyc == 20000) begin
			bad_count++;
			end_sim();
		end
	end

	// ==========================================================
	// host port tasks
	task automatic chk(input string nm, input logic [11:0] got,
			input logic [11:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		io_addr  = a;
		io_wdata = d;
		io_wr    = 1'b1;
		@(posedge sys_clk);
		#1;
		io_wr    = 1'b0;
		@(posedge sys_clk);
		#1;
	endtask
	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		io_addr = a;
		io_rd   = 1'b1;
		@(posedge sys_clk);
		#1;
		d       = io_rdata;
		io_rd   = 1'b0;
		@(posedge sys_clk);
		#1;
	endtask
	task automatic cmd(input logic [7:0] c, input logic [7:0] d);
		wr(asu_pkg::OFF_CMD, c);
		wr(asu_pkg::OFF_DATA0, d);
	endtask
	task automatic st_chk(input string nm, input logic [7:0] exp);
		rd(asu_pkg::OFF_STATUS, s);
		chk(nm, {4'h0, s}, {4'h0, exp});
	endtask
	task automatic get_res(input int ch);
		rd(asu_pkg::OFF_DATA_LO, lo);
		rd(asu_pkg::OFF_DATA_HI, hi);
		chk("result", {hi[3:0], lo}, 12'h800 + 12'(ch) * 12'h111);
		chk("result top", {8'h00, hi[7:4]}, 12'h000);
	endtask
	task automatic wait_irq(input int n);
		int k0;
		k0 = irq_cnt;
		repeat (n) begin
			if (irq_cnt == k0) @(posedge sys_clk);
		end
		#1;
		chk("irq", 12'(irq_cnt != k0), 12'h001);
	endtask
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ==========================================================
	// test sequence
	initial begin
		resetn = 1'b0;
		{io_addr, io_wr, io_rd, io_wdata, gap} = '0;
		{bad_count, checked, cyc, irq_cnt, irq_at, irq_prev, runs} = '0;
		repeat (10) @(posedge sys_clk);
		#1;
		resetn = 1'b1;
		@(posedge sys_clk);
		#1;
		st_chk("status after reset", 8'h00);
		chk("range after reset", {4'h0, range_sel}, 12'h000);
		cmd(asu_pkg::CMD_RANGE, 8'h80);
		@(posedge sys_clk);
		#1;
		chk("range", {4'h0, range_sel}, 12'h080);
		// single channel, software mode, ready source only
		cmd(asu_pkg::CMD_MASK, 8'hFE);
		wr(asu_pkg::OFF_CHAN, 8'h05);
		wait_irq(60);
		chk("run span", {6'h00, rf, rl}, 12'h02D);
		st_chk("ready single", 8'h01);
		get_res(5);
		st_chk("ready drop", 8'h00);
		// zero bits and unused bits leave flags alone
		wr(asu_pkg::OFF_CHAN, 8'h02);
		wait_irq(60);
		wr(asu_pkg::OFF_STATUS, 8'h00);
		wr(asu_pkg::OFF_STATUS, 8'hCA);
		st_chk("status kept", 8'h01);
		wr(asu_pkg::OFF_STATUS, 8'h01);
		st_chk("ready cleared", 8'h00);
		// multi channel with a slow converter
		cmd(asu_pkg::CMD_SET, 8'h04);
		gap = 4'h3;
		wr(asu_pkg::OFF_CHAN, 8'h03);
		repeat (8) @(posedge sys_clk);
		#1;
		st_chk("ready early", 8'h00);
		wait_irq(100);
		chk("multi span", {6'h00, rf, rl}, 12'h003);
		st_chk("ready multi", 8'h01);
		for (int ch = 0; ch < 3; ch++) get_res(ch);
		st_chk("ready partly read", 8'h01);
		get_res(3);
		st_chk("ready all read", 8'h00);
		// clock mode, period step 62 cycles, tick source only
		gap = 4'h0;
		cmd(asu_pkg::CMD_SET, 8'h05);
		cmd(asu_pkg::CMD_PERIOD, 8'h00);
		wr(asu_pkg::OFF_DATA1, 8'h00);
		wr(asu_pkg::OFF_DATA2, 8'h00);
		wr(asu_pkg::OFF_DATA3, 8'h00);
		cmd(asu_pkg::CMD_MASK, 8'hEF);
		wr(asu_pkg::OFF_CHAN, 8'h01);
		wr(asu_pkg::OFF_CMD, asu_pkg::CMD_TSTART);
		wait_irq(200);
		wait_irq(200);
		chk("tick spacing", 12'(irq_at - irq_prev), 12'd62);
		rd(asu_pkg::OFF_STATUS, s);
		chk("tick flag", {11'h000, s[4]}, 12'h001);
		wr(asu_pkg::OFF_STATUS, 8'h10);
		rd(asu_pkg::OFF_STATUS, s);
		chk("tick cleared", {11'h000, s[4]}, 12'h000);
		wait_irq(200);
		wait_irq(200);
		rd(asu_pkg::OFF_STATUS, s);
		chk("overwrite", {10'h000, s[2], s[0]}, 12'h003);
		repeat (20) @(posedge sys_clk);
		#1;
		get_res(0);
		get_res(1);
		wait_irq(200);
		repeat (20) @(posedge sys_clk);
		#1;
		rd(asu_pkg::OFF_STATUS, s);
		chk("overwrite gone", {11'h000, s[2]}, 12'h000);
		// slow runs of eight channels overrun the timer
		wr(asu_pkg::OFF_CMD, asu_pkg::CMD_TSTOP);
		repeat (20) @(posedge sys_clk);
		#1;
		gap = 4'hF;
		wr(asu_pkg::OFF_CHAN, 8'h07);
		k = runs;
		wr(asu_pkg::OFF_CMD, asu_pkg::CMD_TSTART);
		st_chk("start clears", 8'h00);
		repeat (95) @(posedge sys_clk);
		#1;
		wr(asu_pkg::OFF_CMD, asu_pkg::CMD_TSTART);
		rd(asu_pkg::OFF_STATUS, s);
		chk("overrun", {11'h000, s[5]}, 12'h001);
		chk("busy start kept", 12'(runs - k), 12'h001);
		wr(asu_pkg::OFF_CMD, asu_pkg::CMD_INIT);
		rd(asu_pkg::OFF_STATUS, s);
		chk("init clears", {9'h000, s[5], s[4], s[2]}, 12'h000);
		k = irq_cnt;
		repeat (200) @(posedge sys_clk);
		#1;
		chk("all masked", 12'(irq_cnt - k), 12'h000);
		end_sim();
	end
endmodule
